// >>> design/epi_change_det.sv
// Asynchronous pin-change latch with synchronized output for one group.
`timescale 1ns/1ps
module epi_change_det #(
  parameter int N = 8
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic [N-1:0] pins_in,
  input wire logic [N-1:0] mask_in,
  input wire logic clr_in,
  output logic any_out,
  output logic wake_out
);
  import epi_pkg::*;
  logic [N-1:0] ref_reg;
  logic [N-1:0] diff;
  logic sync1_reg;
  logic sync2_reg;
  logic sync3_reg;

  // A masked difference against the last seen level is a pure gate path,
  // so it shows a change even with the clock stopped.
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_bit
      assign diff[g] = mask_in[g] & (pins_in[g] ^ ref_reg[g]);
    end
  endgenerate

  assign wake_out = |diff;

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      ref_reg <= '0;
    end else begin
      ref_reg <= pins_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      sync3_reg <= 1'b0;
    end else begin
      sync1_reg <= wake_out;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  // One pulse per detected change window.
  assign any_out = sync2_reg & ~sync3_reg & ~clr_in;
endmodule

// >>> design/epi_pkg.sv
// Package with register map, field positions and types for the pin interrupts.
package epi_pkg;
  localparam logic [7:0] EPI_OFS_MASK_LO = 8'h12;
  localparam logic [7:0] EPI_OFS_MICRO_CTRL = 8'h35;
  localparam logic [7:0] EPI_OFS_GIRQ_MASK = 8'h3B;
  localparam logic [7:0] EPI_OFS_GIRQ_FLAGS = 8'h3A;
  localparam logic [7:0] EPI_OFS_MASK_HI = 8'h20;
  localparam logic [7:0] EPI_RST_BYTE = 8'h00;
  localparam int EPI_BIT_EXT = 6;
  localparam int EPI_BIT_HI = 5;
  localparam int EPI_BIT_LO = 4;
  localparam logic [7:0] EPI_GIRQ_USED = 8'h70;
  localparam logic [7:0] EPI_MASK_HI_USED = 8'h0F;
  localparam logic [1:0] EPI_SENSE_RST = 2'h0;
  localparam logic [5:0] EPI_MICRO_OTHER_RST = 6'h00;
  localparam logic [15:0] EPI_VEC_EXT = 16'h0001;
  localparam logic [15:0] EPI_VEC_LO = 16'h0002;
  localparam logic [15:0] EPI_VEC_HI = 16'h0003;
  localparam logic [15:0] EPI_VEC_NONE = 16'h0000;
  localparam int EPI_SYNC_STAGES = 2;

  typedef enum logic [1:0] {
    EPI_SENSE_LOW = 2'b00,
    EPI_SENSE_ANY = 2'b01,
    EPI_SENSE_FALL = 2'b10,
    EPI_SENSE_RISE = 2'b11
  } epi_sense_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } epi_bus_req_t;

  typedef struct packed {
    logic ext;
    logic hi;
    logic lo;
  } epi_ack_t;
endpackage

// >>> design/epi_top.sv
// External pin and pin-change interrupt logic with its register file.
//
// Overview of operation
// - Pins raise requests regardless of their direction; inputs are raw levels.
// - Group low requests when any unmasked change input 7..0 toggles.
// - Group high requests when any unmasked change input 11..8 toggles.
// - Change detection has a combinational wake path needing no clock.
// - Sense field picks low level, any change, falling or rising edge.
// - Low level with enable keeps requesting while the pin stays low.
// - Edge detection runs on the clock and stops when it stops.
// - Low-level detection has a combinational wake path needing no clock.
// - Level gone before wake-up means wake but no request afterwards.
// - Pin is sampled before edge detection; pulses over a period count.
// - Mask bit 6 with global flag gates the pin request to its vector.
// - Mask bit 5 with global flag gates group high to its vector.
// - Mask bit 4 with global flag gates group low to its vector.
// - Pin trigger sets flag bit 6; acknowledge or writing one clears it.
// - In level mode the pin flag reads as zero always.
// - Group high change sets flag bit 5; acknowledge or one clears.
// - Group low change sets flag bit 4; acknowledge or one clears.
// - Reserved bits of mask, flag and high mask registers read zero.
// - High mask bits 3..0 enable inputs 11..8 together with group enable.
// - Low mask bits 7..0 enable inputs 7..0 together with group enable.
// - Vectors are 0x0001 for the pin, 0x0002 low group, 0x0003 high.
`timescale 1ns/1ps
module epi_top (
  input wire logic MCLK_IN,
  input wire logic NRST_IN,
  input wire epi_pkg::epi_bus_req_t BUS_IN,
  output logic [7:0] RDATA_OUT,
  input wire logic GLOBAL_IE_IN,
  input wire epi_pkg::epi_ack_t ACK_IN,
  input wire logic EXT_IRQ_PIN_IN,
  input wire logic [11:0] CHANGE_INPUTS_IN,
  output logic IRQ_REQ_OUT,
  output logic [15:0] IRQ_VECTOR_OUT,
  output logic WAKE_OUT,
  output logic [5:0] MICRO_OTHER_OUT
);
  import epi_pkg::*;

  logic [7:0] change_mask_lo_reg;
  logic [3:0] change_mask_hi_reg;
  logic [1:0] sense_reg;
  logic [5:0] micro_other_reg;
  logic ext_en_reg;
  logic change_hi_en_reg;
  logic change_lo_en_reg;
  logic ext_irq_flag_reg;
  logic change_hi_flag_reg;
  logic change_lo_flag_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic [EPI_SYNC_STAGES-1:0] pin_sync_reg;
  logic pin_prev_reg;
  logic pin_s;
  logic ext_edge;
  logic ext_level;
  logic lo_change;
  logic hi_change;
  logic lo_wake;
  logic hi_wake;
  logic wr_flags;
  logic level_mode;
  logic ext_req;
  logic hi_req;
  logic lo_req;
  logic [7:0] mask_lo_eff;
  logic [3:0] mask_hi_eff;
  epi_sense_t sense;

  assign sense = epi_sense_t'(sense_reg);
  assign level_mode = (sense == EPI_SENSE_LOW);
  assign wr_flags = BUS_IN.wr && (BUS_IN.addr == EPI_OFS_GIRQ_FLAGS);
  assign MICRO_OTHER_OUT = micro_other_reg;

  // Register writes.
  always_ff @(posedge MCLK_IN) begin
    if (!NRST_IN) begin
      change_mask_lo_reg <= EPI_RST_BYTE;
      change_mask_hi_reg <= EPI_RST_BYTE[3:0];
      sense_reg <= EPI_SENSE_RST;
      micro_other_reg <= EPI_MICRO_OTHER_RST;
      ext_en_reg <= 1'b0;
      change_hi_en_reg <= 1'b0;
      change_lo_en_reg <= 1'b0;
    end else if (BUS_IN.wr) begin
      unique case (BUS_IN.addr)
        EPI_OFS_MASK_LO: change_mask_lo_reg <= BUS_IN.wdata;
        EPI_OFS_MASK_HI: change_mask_hi_reg <= BUS_IN.wdata[3:0];
        EPI_OFS_MICRO_CTRL: begin
          sense_reg <= BUS_IN.wdata[1:0];
          micro_other_reg <= BUS_IN.wdata[7:2];
        end
        EPI_OFS_GIRQ_MASK: begin
          ext_en_reg <= BUS_IN.wdata[EPI_BIT_EXT];
          change_hi_en_reg <= BUS_IN.wdata[EPI_BIT_HI];
          change_lo_en_reg <= BUS_IN.wdata[EPI_BIT_LO];
        end
        default: begin
        end
      endcase
    end
  end

  // Read mux; unmapped addresses and reserved bits read as zero.
  always_comb begin
    rdata_next = 8'h00;
    unique case (BUS_IN.addr)
      EPI_OFS_MASK_LO: rdata_next = change_mask_lo_reg;
      EPI_OFS_MASK_HI: rdata_next = {4'h0, change_mask_hi_reg};
      EPI_OFS_MICRO_CTRL: rdata_next = {micro_other_reg, sense_reg};
      EPI_OFS_GIRQ_MASK: begin
        rdata_next[EPI_BIT_EXT] = ext_en_reg;
        rdata_next[EPI_BIT_HI] = change_hi_en_reg;
        rdata_next[EPI_BIT_LO] = change_lo_en_reg;
      end
      EPI_OFS_GIRQ_FLAGS: begin
        rdata_next[EPI_BIT_EXT] = ext_irq_flag_reg & ~level_mode;
        rdata_next[EPI_BIT_HI] = change_hi_flag_reg;
        rdata_next[EPI_BIT_LO] = change_lo_flag_reg;
      end
      default: rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge MCLK_IN) begin
    if (!NRST_IN) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= BUS_IN.rd ? (rdata_next & 8'hFF) : 8'h00;
    end
  end
  assign RDATA_OUT = rdata_reg;

  // Pin is sampled by a two-stage synchronizer before edges are compared.
  always_ff @(posedge MCLK_IN) begin
    if (!NRST_IN) begin
      pin_sync_reg <= '1;
      pin_prev_reg <= 1'b1;
    end else begin
      pin_sync_reg <= {pin_sync_reg[0], EXT_IRQ_PIN_IN};
      pin_prev_reg <= pin_sync_reg[1];
    end
  end
  assign pin_s = pin_sync_reg[1];

  always_comb begin
    ext_edge = 1'b0;
    unique case (sense)
      EPI_SENSE_LOW: ext_edge = 1'b0;
      EPI_SENSE_ANY: ext_edge = pin_s ^ pin_prev_reg;
      EPI_SENSE_FALL: ext_edge = pin_prev_reg & ~pin_s;
      EPI_SENSE_RISE: ext_edge = ~pin_prev_reg & pin_s;
    endcase
  end

  // Level request follows the synchronized pin, so it ends once the pin is
  // released and no request is left behind.
  assign ext_level = level_mode & ~pin_s;

  assign mask_lo_eff = change_mask_lo_reg & {8{change_lo_en_reg}};
  assign mask_hi_eff = change_mask_hi_reg & {4{change_hi_en_reg}};

  epi_change_det #(.N(8)) u_lo (
    .clk_in(MCLK_IN),
    .nrst_in(NRST_IN),
    .pins_in(CHANGE_INPUTS_IN[7:0]),
    .mask_in(mask_lo_eff),
    .clr_in(1'b0),
    .any_out(lo_change),
    .wake_out(lo_wake)
  );

  epi_change_det #(.N(4)) u_hi (
    .clk_in(MCLK_IN),
    .nrst_in(NRST_IN),
    .pins_in(CHANGE_INPUTS_IN[11:8]),
    .mask_in(mask_hi_eff),
    .clr_in(1'b0),
    .any_out(hi_change),
    .wake_out(hi_wake)
  );

  // Clockless wake path for level and pin-change sources.
  assign WAKE_OUT = lo_wake | hi_wake
    | (ext_en_reg & level_mode & ~EXT_IRQ_PIN_IN);

  // Flags: a set in the same cycle as a clear wins.
  always_ff @(posedge MCLK_IN) begin
    if (!NRST_IN) begin
      ext_irq_flag_reg <= 1'b0;
    end else if (ext_edge) begin
      ext_irq_flag_reg <= 1'b1;
    end else if (level_mode || ACK_IN.ext ||
                 (wr_flags && BUS_IN.wdata[EPI_BIT_EXT])) begin
      ext_irq_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge MCLK_IN) begin
    if (!NRST_IN) begin
      change_hi_flag_reg <= 1'b0;
    end else if (hi_change) begin
      change_hi_flag_reg <= 1'b1;
    end else if (ACK_IN.hi || (wr_flags && BUS_IN.wdata[EPI_BIT_HI])) begin
      change_hi_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge MCLK_IN) begin
    if (!NRST_IN) begin
      change_lo_flag_reg <= 1'b0;
    end else if (lo_change) begin
      change_lo_flag_reg <= 1'b1;
    end else if (ACK_IN.lo || (wr_flags && BUS_IN.wdata[EPI_BIT_LO])) begin
      change_lo_flag_reg <= 1'b0;
    end
  end

  assign ext_req = GLOBAL_IE_IN & ext_en_reg
    & (ext_irq_flag_reg | ext_level);
  assign hi_req = GLOBAL_IE_IN & change_hi_en_reg
    & change_hi_flag_reg;
  assign lo_req = GLOBAL_IE_IN & change_lo_en_reg
    & change_lo_flag_reg;
  assign IRQ_REQ_OUT = ext_req | hi_req | lo_req;

  // Fixed priority by vector number.
  always_comb begin
    if (ext_req) begin
      IRQ_VECTOR_OUT = EPI_VEC_EXT;
    end else if (lo_req) begin
      IRQ_VECTOR_OUT = EPI_VEC_LO;
    end else if (hi_req) begin
      IRQ_VECTOR_OUT = EPI_VEC_HI;
    end else begin
      IRQ_VECTOR_OUT = EPI_VEC_NONE;
    end
  end

  // The core holds a low level until its instruction completes; the level
  // request needs no latch here for that reason.

  property p_flag_set;
    @(posedge MCLK_IN) disable iff (!NRST_IN)
      ext_edge |=> ext_irq_flag_reg;
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("pin flag not set after edge");

  property p_level_reads_zero;
    @(posedge MCLK_IN) disable iff (!NRST_IN)
      (BUS_IN.rd && BUS_IN.addr == EPI_OFS_GIRQ_FLAGS && level_mode)
        |=> !RDATA_OUT[EPI_BIT_EXT];
  endproperty
  a_level_reads_zero: assert property (p_level_reads_zero)
    else $error("pin flag visible in level mode");

  property p_reserved_zero;
    @(posedge MCLK_IN) disable iff (!NRST_IN)
      (BUS_IN.rd && (BUS_IN.addr == EPI_OFS_GIRQ_FLAGS ||
       BUS_IN.addr == EPI_OFS_GIRQ_MASK))
        |=> ((RDATA_OUT & ~EPI_GIRQ_USED) == 8'h00);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved bit read as one");

  property p_fall_edge;
    @(posedge MCLK_IN) disable iff (!NRST_IN)
      (sense == EPI_SENSE_FALL && $fell(pin_s) && !wr_flags && !ACK_IN.ext)
        |=> ext_irq_flag_reg;
  endproperty
  a_fall_edge: assert property (p_fall_edge)
    else $error("falling edge missed");

  property p_level_req;
    @(posedge MCLK_IN) disable iff (!NRST_IN)
      (GLOBAL_IE_IN && ext_en_reg && level_mode && !pin_s)
        |-> IRQ_REQ_OUT && IRQ_VECTOR_OUT == EPI_VEC_EXT;
  endproperty
  a_level_req: assert property (p_level_req)
    else $error("level request missing");

  property p_gate_global;
    @(posedge MCLK_IN) disable iff (!NRST_IN)
      !GLOBAL_IE_IN |-> !IRQ_REQ_OUT;
  endproperty
  a_gate_global: assert property (p_gate_global)
    else $error("request without global enable");

  property p_lo_change;
    @(posedge MCLK_IN) disable iff (!NRST_IN)
      lo_wake |-> ##[1:3] change_lo_flag_reg;
  endproperty
  a_lo_change: assert property (p_lo_change)
    else $error("low group change lost");

  property p_hi_clear;
    @(posedge MCLK_IN) disable iff (!NRST_IN)
      (ACK_IN.hi && !hi_change) |=> !change_hi_flag_reg;
  endproperty
  a_hi_clear: assert property (p_hi_clear)
    else $error("high flag not cleared");

  property p_lo_mask;
    @(posedge MCLK_IN) disable iff (!NRST_IN)
      !change_lo_en_reg |-> !lo_wake;
  endproperty
  a_lo_mask: assert property (p_lo_mask)
    else $error("disabled low group woke");

  property p_hi_change;
    @(posedge MCLK_IN) disable iff (!NRST_IN)
      hi_wake |-> ##[1:3] change_hi_flag_reg;
  endproperty
  a_hi_change: assert property (p_hi_change)
    else $error("high group change lost");

  property p_lo_clear;
    @(posedge MCLK_IN) disable iff (!NRST_IN)
      (ACK_IN.lo && !lo_change) |=> !change_lo_flag_reg;
  endproperty
  a_lo_clear: assert property (p_lo_clear)
    else $error("low flag not cleared");

  property p_rise_edge;
    @(posedge MCLK_IN) disable iff (!NRST_IN)
      (sense == EPI_SENSE_RISE && $rose(pin_s)) |=> ext_irq_flag_reg;
  endproperty
  a_rise_edge: assert property (p_rise_edge)
    else $error("rising edge missed");

  property p_lo_vec;
    @(posedge MCLK_IN) disable iff (!NRST_IN)
      (lo_req && !ext_req) |-> IRQ_VECTOR_OUT == EPI_VEC_LO;
  endproperty
  a_lo_vec: assert property (p_lo_vec)
    else $error("low group vector wrong");

  c_ext_vec: cover property (@(posedge MCLK_IN) IRQ_VECTOR_OUT == EPI_VEC_EXT);
  c_lo_vec: cover property (@(posedge MCLK_IN) IRQ_VECTOR_OUT == EPI_VEC_LO);
  c_hi_vec: cover property (@(posedge MCLK_IN) IRQ_VECTOR_OUT == EPI_VEC_HI);
  c_rise: cover property (@(posedge MCLK_IN)
    sense == EPI_SENSE_RISE && ext_edge);
endmodule

// >>> testbench/epi_cpu_model.sv
// CPU dispatch model that takes pending vectors with acknowledge pulses.
`timescale 1ns/1ps
module epi_cpu_model
  import epi_pkg::*;
(
  input wire logic clk_in,
  input wire logic req_in,
  input wire logic [15:0] vector_in,
  input wire logic take_en_in,
  input wire logic [3:0] delay_in,
  output epi_pkg::epi_ack_t ack_out
);
  int wait_cnt = 0;
  // The request must stand for delay_in cycles before its vector is taken.
  always @(posedge clk_in) begin
    ack_out <= '0;
    if (take_en_in && req_in === 1'b1 && ack_out === '0) begin
      if (wait_cnt >= int'(delay_in)) begin
        wait_cnt <= 0;
        ack_out.ext <= (vector_in === EPI_VEC_EXT);
        ack_out.lo <= (vector_in === EPI_VEC_LO);
        ack_out.hi <= (vector_in === EPI_VEC_HI);
      end else begin
        wait_cnt <= wait_cnt + 1;
      end
    end else begin
      wait_cnt <= 0;
    end
  end
endmodule

// >>> testbench/tb_top.sv
// Self-checking bench for the pin and pin-change interrupt block.
`timescale 1ns/1ps
module tb_top;
  import epi_pkg::*;
  logic clk, nrst, gie, pin, take, wake, req;
  logic [11:0] chg;
  logic [3:0] dly;
  logic [7:0] rdata;
  logic [5:0] other;
  logic [15:0] vec;
  logic [31:0] seed;
  epi_bus_req_t bus;
  epi_ack_t ack;
  int err_count, num_checks;

  epi_top epi_top_inst (.MCLK_IN(clk), .NRST_IN(nrst), .BUS_IN(bus),
    .RDATA_OUT(rdata), .GLOBAL_IE_IN(gie), .ACK_IN(ack),
    .EXT_IRQ_PIN_IN(pin), .CHANGE_INPUTS_IN(chg), .IRQ_REQ_OUT(req),
    .IRQ_VECTOR_OUT(vec), .WAKE_OUT(wake), .MICRO_OTHER_OUT(other));
  epi_cpu_model epi_cpu_model_inst (.clk_in(clk), .req_in(req),
    .vector_in(vec), .take_en_in(take), .delay_in(dly), .ack_out(ack));

  always #50 clk = ~clk;

  function logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic chk(input logic [16:0] got, input logic [16:0] e);
    num_checks++;
    if (got !== e) begin
      err_count++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus <= '0;
  endtask

  task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus <= '0;
    #1;
    chk({9'h000, rdata}, {9'h000, e});
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial begin
    #5000000;
    err_count++;
    final_report();
  end

  initial begin
    logic [7:0] ofs [6];
    logic [7:0] ml, mh, en;
    logic [15:0] q [3];
    logic [15:0] prev;
    int b, n;
    logic hit_lo, hit_hi, e;
    ofs = '{8'h12, 8'h35, 8'h3B, 8'h3A, 8'h20, 8'h77};
    q = '{EPI_VEC_LO, EPI_VEC_HI, EPI_VEC_NONE};
    clk = 0; nrst = 0; bus = '0; gie = 0; pin = 1; take = 0;
    chg = '0; dly = 4'h8; seed = 32'd94; err_count = 0; num_checks = 0;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    foreach (ofs[i]) chk_rd(ofs[i], 8'h00);
    wr(8'h3B, 8'hFF);
    chk_rd(8'h3B, 8'h70);
    wr(8'h20, 8'hFF);
    chk_rd(8'h20, 8'h0F);
    wr(8'h3A, 8'hFF);
    chk_rd(8'h3A, 8'h00);
    wr(8'h35, 8'hA5);
    chk_rd(8'h35, 8'hA5);
    chk({11'h000, other}, {11'h000, 6'h29});
    wr(8'h3B, 8'h00);
    $display("test registers done");
    for (int m = 1; m < 4; m++) begin
      wr(8'h35, 8'(m));
      for (int r = 0; r < 2; r++) begin
        wr(8'h3A, 8'h40);
        @(posedge clk);
        pin <= r[0];
        e = (m == 1) || (m == 2 && r == 0) || (m == 3 && r == 1);
        repeat (5) @(posedge clk);
        chk_rd(8'h3A, e ? 8'h40 : 8'h00);
        wr(8'h3A, 8'h40);
        chk_rd(8'h3A, 8'h00);
      end
    end
    $display("test edges done");
    wr(8'h35, 8'h00);
    wr(8'h3B, 8'h40);
    gie <= 1'b1;
    pin <= 1'b0;
    #1;
    chk({16'h0000, wake}, 17'h00001);
    repeat (14) @(posedge clk);
    #1;
    chk({req, vec}, {1'b1, EPI_VEC_EXT});
    chk_rd(8'h3A, 8'h00);
    gie <= 1'b0;
    #1;
    chk({req, vec}, 17'h00000);
    gie <= 1'b1;
    pin <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    chk({req, vec}, 17'h00000);
    gie <= 1'b0;
    wr(8'h3B, 8'h00);
    $display("test level done");
    for (int i = 0; i < 24; i++) begin
      ml = xs();
      mh = xs();
      en = xs() & 8'h30;
      b = int'(xs() % 12);
      wr(8'h12, ml);
      wr(8'h20, mh);
      wr(8'h3B, en);
      hit_lo = b < 8 && ml[b] && en[4];
      hit_hi = b >= 8 && mh[b-8] && en[5];
      @(posedge clk);
      chg <= chg ^ (12'h001 << b);
      #1;
      chk({16'h0000, wake}, {16'h0000, hit_lo | hit_hi});
      repeat (5) @(posedge clk);
      chk_rd(8'h3A, {2'b00, hit_hi, hit_lo, 4'h0});
      wr(8'h3A, 8'h30);
    end
    $display("test change groups done");
    wr(8'h12, 8'hFF);
    wr(8'h20, 8'h0F);
    wr(8'h3B, 8'h70);
    wr(8'h3A, 8'hFF);
    gie <= 1'b1;
    take <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      dly <= k ? 4'h1 : 4'h8;
      @(posedge clk);
      chg <= chg ^ 12'h101;
      prev = EPI_VEC_NONE;
      foreach (q[i]) begin
        n = 0;
        #1;
        while (vec === prev && n < 60) begin
          @(posedge clk);
          #1;
          n++;
        end
        chk({req, vec}, {q[i] != 16'h0000, q[i]});
        prev = q[i];
      end
      chk_rd(8'h3A, 8'h00);
    end
    take <= 1'b0;
    gie <= 1'b0;
    $display("test dispatch done");
    final_report();
  end
endmodule
